// ### include/dasa_pkg.sv
// constants and types shared by the diagnostic alarm status and alert bank
package dasa_pkg;

   // =====================================================================
   // status and mask word layout
   localparam int          STAT_W          = 16;
   localparam int          BIT_BLOCK_A     = 2;
   localparam int          BIT_FLUCT_LO    = 3;
   localparam int          BIT_FLUCT_HI    = 4;
   localparam int          BIT_SIDE_LO     = 5;
   localparam int          BIT_SIDE_HI     = 6;
   localparam int          BIT_BLOCK_B     = 7;
   localparam int          BIT_INV_BLOCKAGE_FACTOR    = 8;
   localparam int          BIT_INV_SPH     = 9;
   localparam int          BIT_INV_SPL     = 10;
   localparam int          BIT_INV_DP      = 11;
   localparam int          BIT_OVER_RANGE  = 12;
   localparam int          BIT_FT_LOW      = 13;
   localparam int          BIT_FT_HIGH     = 14;
   localparam int          BLOCK_W         = 6;
   localparam int          INV_W           = 4;
   localparam logic [15:0] MASK_RESET      = 16'h08FC;
   localparam logic [15:0] MASK_WRITABLE   = 16'h7FFC;
   localparam logic [15:0] ANALOG_EXCLUDE  = 16'h1F00;
   localparam logic [15:0] STATUS_RESET    = 16'h0000;

   // =====================================================================
   // configuration port selectors
   localparam logic [2:0]  SEL_MODE        = 3'h0;
   localparam logic [2:0]  SEL_MASK        = 3'h1;
   localparam logic [2:0]  SEL_UPPER       = 3'h2;
   localparam logic [2:0]  SEL_LOWER       = 3'h3;
   localparam logic [2:0]  SEL_OUT_OPTION  = 3'h4;
   localparam logic [2:0]  SEL_FALLBACK    = 3'h5;
   localparam logic [2:0]  SEL_STATUS      = 3'h6;

   // =====================================================================
   // written codes of operating mode and output action
   localparam logic [1:0]  MODE_CODE_STOP  = 2'h0;
   localparam logic [1:0]  MODE_CODE_CALC  = 2'h1;
   localparam logic [1:0]  MODE_CODE_REF   = 2'h2;
   localparam logic [1:0]  OUT_OFF         = 2'h0;
   localparam logic [1:0]  OUT_BURNOUT     = 2'h1;
   localparam logic [1:0]  OUT_FALLBACK    = 2'h2;
   localparam logic [1:0]  OUT_OPTION_RESET = 2'h0;

   // =====================================================================
   // numeric formats: pressure ratio signed Q3.13 (1.0 = 0x2000), current uA
   localparam logic [15:0] UPPER_RESET     = 16'h2000;
   localparam logic [15:0] LOWER_RESET     = 16'hE000;
   localparam logic [15:0] FALLBACK_MIN_UA = 16'h0E10;
   localparam logic [15:0] FALLBACK_MAX_UA = 16'h5460;
   localparam logic [15:0] FALLBACK_RESET  = 16'h0E10;

   // gray codes along stop -> reference -> calculation
   typedef enum logic [1:0] {
      DASA_STOP = 2'b00,
      DASA_REF  = 2'b01,
      DASA_CALC = 2'b11
   } dasa_mode_e;

endpackage

// ### verilog/dasa_alarm_bank.sv
// diagnostic alarm status, link mask and analog alert action
//
// Function
// - every detector or heat-trace abnormality sets a bit in the status word
// - bits 0,1,15 unused; bits 2..7 are the six blockage flags
// - bits 8..11 flag invalid blockage, high, low, differential references
// - bit 12 over range, bit 13 flange low, bit 14 flange high
// - mean pressure above upper limit sets over range, suspends detection
// - mean pressure below lower limit sets over range, suspends detection
// - range limits accept writes only while mode is Stop
// - invalid blockage-factor reference suspends only blockage-factor checks
// - reference mean outside limits sets all four invalid-reference flags
// - mask bit gates same status bit onto alert and display
// - mask resets to 0x08FC
// - only mask bits 2..14 can be set
// - output action Off keeps analog output on primary variable
// - Burnout drives upper or lower bound by burnout switch
// - Fall back holds analog output at fallback level
// - fallback level accepts only 3.6 to 21.6 mA
// - modes Stop, Calculation, Reference; Reference ends in Calculation
// - invalid-reference and over-range flags never drive analog output
`timescale 1ns/100ps

module dasa_alarm_bank
   import dasa_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               sys_rst,
   // configuration access from the link stack
   input  wire logic               cfgWrite,
   input  wire logic [2:0]         cfgSel,
   input  wire logic [15:0]        cfgData,
   output logic                    cfgAck,
   output logic                    cfgNak,
   output logic [15:0]             cfgReadData,
   // detector results
   input  wire logic               resultValid,
   input  wire logic [BLOCK_W-1:0] blockResult,
   input  wire logic [INV_W-1:0]   refInvalid,
   input  wire logic               refDone,
   input  wire logic signed [15:0] normalizedMeanPressure,
   input  wire logic signed [15:0] referenceMeanPressure,
   input  wire logic               flangeTempLowFlag,
   input  wire logic               flangeTempHighFlag,
   // analog loop
   input  wire logic [15:0]        pvCurrent,
   input  wire logic [15:0]        outputUpperBound,
   input  wire logic [15:0]        outputLowerBound,
   input  wire logic               burnoutSwitchHigh,
   output logic [15:0]             aoCurrent,
   // detector control and alarm outputs
   output logic                    detectEnable,
   output logic                    blockFactorEnable,
   output logic                    refSampleStart,
   output logic                    diagAlert,
   output logic                    analogAlert,
   output logic [15:0]             diagnosticAlarmStatus,
   output logic [15:0]             alarmLinkMask,
   output dasa_mode_e              diagMode
);

   // =====================================================================
   // burnout switch synchroniser
   logic burnMeta;
   logic burnSync;
   logic next_burnMeta;
   logic next_burnSync;

   always_comb begin
      next_burnMeta = burnoutSwitchHigh;
      next_burnSync = burnMeta;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         burnMeta <= 1'b0;
         burnSync <= 1'b0;
      end else begin
         burnMeta <= next_burnMeta;
         burnSync <= next_burnSync;
      end
   end

   // =====================================================================
   // configuration registers and operating mode
   logic        [1:0]  outOption;
   logic signed [15:0] rangeUpperLimit;
   logic signed [15:0] rangeLowerLimit;
   logic        [15:0] fallbackLevel;
   dasa_mode_e         next_diagMode;
   dasa_mode_e         autoMode;
   logic        [15:0] next_alarmLinkMask;
   logic        [1:0]  next_outOption;
   logic signed [15:0] next_rangeUpperLimit;
   logic signed [15:0] next_rangeLowerLimit;
   logic        [15:0] next_fallbackLevel;
   logic               next_cfgAck;
   logic               next_cfgNak;
   logic               next_refSampleStart;
   logic               accept;

   always_comb begin
      next_diagMode        = diagMode;
      next_alarmLinkMask   = alarmLinkMask;
      next_outOption       = outOption;
      next_rangeUpperLimit = rangeUpperLimit;
      next_rangeLowerLimit = rangeLowerLimit;
      next_fallbackLevel   = fallbackLevel;
      next_refSampleStart  = 1'b0;
      accept               = 1'b0;
      if (diagMode == DASA_REF && refDone) begin
         next_diagMode = DASA_CALC;
      end
      // a refused mode write must not cancel the automatic move
      autoMode = next_diagMode;
      if (cfgWrite) begin
         case (cfgSel)
            SEL_MODE: begin
               accept = 1'b1;
               case (cfgData[1:0])
                  MODE_CODE_STOP: next_diagMode = DASA_STOP;
                  MODE_CODE_CALC: next_diagMode = DASA_CALC;
                  MODE_CODE_REF: begin
                     next_diagMode       = DASA_REF;
                     next_refSampleStart = 1'b1;
                  end
                  default: accept = 1'b0;
               endcase
               if (cfgData[15:2] != 14'h0000) begin
                  accept = 1'b0;
               end
               if (!accept) begin
                  next_diagMode       = autoMode;
                  next_refSampleStart = 1'b0;
               end
            end
            SEL_MASK: begin
               next_alarmLinkMask = cfgData & MASK_WRITABLE;
               accept             = 1'b1;
            end
            SEL_UPPER: begin
               if (diagMode == DASA_STOP) begin
                  next_rangeUpperLimit = cfgData;
                  accept               = 1'b1;
               end
            end
            SEL_LOWER: begin
               if (diagMode == DASA_STOP) begin
                  next_rangeLowerLimit = cfgData;
                  accept               = 1'b1;
               end
            end
            SEL_OUT_OPTION: begin
               if (cfgData[15:2] == 14'h0000 && cfgData[1:0] != 2'h3) begin
                  next_outOption = cfgData[1:0];
                  accept         = 1'b1;
               end
            end
            SEL_FALLBACK: begin
               if (cfgData >= FALLBACK_MIN_UA &&
                   cfgData <= FALLBACK_MAX_UA) begin
                  next_fallbackLevel = cfgData;
                  accept             = 1'b1;
               end
            end
            default: accept = 1'b0;
         endcase
      end
      next_cfgAck = cfgWrite & accept;
      next_cfgNak = cfgWrite & ~accept;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         diagMode        <= DASA_STOP;
         alarmLinkMask   <= MASK_RESET;
         outOption       <= OUT_OPTION_RESET;
         rangeUpperLimit <= UPPER_RESET;
         rangeLowerLimit <= LOWER_RESET;
         fallbackLevel   <= FALLBACK_RESET;
         cfgAck          <= 1'b0;
         cfgNak          <= 1'b0;
         refSampleStart  <= 1'b0;
      end else begin
         diagMode        <= next_diagMode;
         alarmLinkMask   <= next_alarmLinkMask;
         outOption       <= next_outOption;
         rangeUpperLimit <= next_rangeUpperLimit;
         rangeLowerLimit <= next_rangeLowerLimit;
         fallbackLevel   <= next_fallbackLevel;
         cfgAck          <= next_cfgAck;
         cfgNak          <= next_cfgNak;
         refSampleStart  <= next_refSampleStart;
      end
   end

   // =====================================================================
   // range checks on live and reference mean pressure
   logic overRange;
   logic refOutside;
   logic calcActive;

   assign overRange  = (normalizedMeanPressure > rangeUpperLimit) ||
                       (normalizedMeanPressure < rangeLowerLimit);
   assign refOutside = (referenceMeanPressure > rangeUpperLimit) ||
                       (referenceMeanPressure < rangeLowerLimit);
   assign calcActive = (diagMode == DASA_CALC);

   // =====================================================================
   // status word
   logic [15:0] next_status;
   logic [INV_W-1:0] invalidNow;
   logic        next_detectEnable;
   logic        next_blockFactorEnable;

   always_comb begin
      next_status = diagnosticAlarmStatus;
      invalidNow  = refInvalid | {INV_W{refOutside}};
      next_detectEnable      = calcActive & ~overRange;
      next_blockFactorEnable = next_detectEnable & ~invalidNow[0];
      // a fresh reference sampling discards stale blockage results
      if (next_refSampleStart) begin
         next_status[BIT_BLOCK_B:BIT_BLOCK_A] = {BLOCK_W{1'b0}};
      end
      // blockage results latched, a same-cycle report wins
      if (resultValid && next_detectEnable) begin
         next_status[BIT_BLOCK_B:BIT_BLOCK_A] = blockResult;
      end
      next_status[BIT_INV_DP:BIT_INV_BLOCKAGE_FACTOR] = invalidNow;
      next_status[BIT_OVER_RANGE] = overRange;
      next_status[BIT_FT_LOW]     = flangeTempLowFlag;
      next_status[BIT_FT_HIGH]    = flangeTempHighFlag;
      next_status[1:0]            = 2'b00;
      next_status[15]             = 1'b0;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         diagnosticAlarmStatus <= STATUS_RESET;
         detectEnable          <= 1'b0;
         blockFactorEnable     <= 1'b0;
      end else begin
         diagnosticAlarmStatus <= next_status;
         detectEnable          <= next_detectEnable;
         blockFactorEnable     <= next_blockFactorEnable;
      end
   end

   // =====================================================================
   // alert and analog output action
   logic [15:0] linked;
   logic        next_diagAlert;
   logic        next_analogAlert;
   logic [15:0] next_aoCurrent;
   logic [15:0] next_cfgReadData;

   always_comb begin
      linked           = diagnosticAlarmStatus & alarmLinkMask;
      next_diagAlert   = (linked != 16'h0000);
      // invalid and over-range never reach analog
      next_analogAlert = ((linked & ~ANALOG_EXCLUDE) != 16'h0000);
      next_aoCurrent   = pvCurrent;
      if (next_analogAlert) begin
         case (outOption)
            OUT_BURNOUT: next_aoCurrent = burnSync ? outputUpperBound
                                                   : outputLowerBound;
            OUT_FALLBACK: next_aoCurrent = fallbackLevel;
            default: next_aoCurrent = pvCurrent;
         endcase
      end
      case (cfgSel)
         SEL_MODE:       next_cfgReadData = {14'h0000, diagMode};
         SEL_MASK:       next_cfgReadData = alarmLinkMask;
         SEL_UPPER:      next_cfgReadData = rangeUpperLimit;
         SEL_LOWER:      next_cfgReadData = rangeLowerLimit;
         SEL_OUT_OPTION: next_cfgReadData = {14'h0000, outOption};
         SEL_FALLBACK:   next_cfgReadData = fallbackLevel;
         SEL_STATUS:     next_cfgReadData = diagnosticAlarmStatus;
         default:        next_cfgReadData = 16'h0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         diagAlert   <= 1'b0;
         analogAlert <= 1'b0;
         aoCurrent   <= 16'h0000;
         cfgReadData <= 16'h0000;
      end else begin
         diagAlert   <= next_diagAlert;
         analogAlert <= next_analogAlert;
         aoCurrent   <= next_aoCurrent;
         cfgReadData <= next_cfgReadData;
      end
   end

endmodule

// ### verif/dasa_cfg_tool.sv
// configuration tool model driving the register write port
`timescale 1ns/100ps
module dasa_cfg_tool
   import dasa_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        cfgAck,
   input  wire logic        cfgNak,
   output logic             cfgWrite,
   output logic [2:0]       cfgSel,
   output logic [15:0]      cfgData
);
   initial begin
      cfgWrite = 1'b0;
      cfgSel   = SEL_STATUS;
      cfgData  = 16'h0000;
   end
   // request held until the answer edge, data inverted once released
   task automatic put(input logic [2:0] sel, input logic [15:0] d,
                      output logic ack, output logic nak);
      @(negedge clk);
      cfgWrite = 1'b1;
      cfgSel   = sel;
      cfgData  = d;
      @(negedge clk);
      ack      = cfgAck;
      nak      = cfgNak;
      cfgWrite = 1'b0;
      cfgSel   = SEL_STATUS;
      cfgData  = ~d;
   endtask
   task automatic guarded(input logic [2:0] sel, input logic [15:0] d,
                          output logic ack);
      logic n;
      put(SEL_MODE, {14'h0000, MODE_CODE_STOP}, ack, n);
      put(sel, d, ack, n);
      put(SEL_MODE, {14'h0000, MODE_CODE_CALC}, n, n);
   endtask
endmodule

// ### verif/dasa_alarm_bank_checker.sv
// concurrent checks on the alarm bank ports
`timescale 1ns/100ps
module dasa_alarm_bank_checker
   import dasa_pkg::*;
(
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        cfgWrite,
   input wire logic [2:0]  cfgSel,
   input wire logic [15:0] cfgData,
   input wire logic        cfgAck,
   input wire logic        cfgNak,
   input wire logic        flangeTempLowFlag,
   input wire logic        flangeTempHighFlag,
   input wire logic        detectEnable,
   input wire logic        refSampleStart,
   input wire logic        diagAlert,
   input wire logic        analogAlert,
   input wire logic [15:0] diagnosticAlarmStatus,
   input wire logic [15:0] alarmLinkMask,
   input wire dasa_mode_e  diagMode
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire [15:0] linked = diagnosticAlarmStatus & alarmLinkMask;
   // =====================================================================
   // assertions
   AST_MASK_RESET: assert property ($past(sys_rst) |->
      alarmLinkMask == MASK_RESET) else $error("mask not at reset value");
   AST_MASK_WRITE: assert property (cfgWrite && cfgSel == SEL_MASK
      |=> cfgAck && alarmLinkMask == ($past(cfgData) & MASK_WRITABLE))
      else $error("mask write wrong");
   AST_UNUSED: assert property (diagnosticAlarmStatus[1:0] == 2'b00
      && !diagnosticAlarmStatus[15]) else $error("unused status bit set");
   AST_FLANGE: assert property (1'b1 |=> diagnosticAlarmStatus[14:13] ==
      $past({flangeTempHighFlag, flangeTempLowFlag}))
      else $error("flange flags not tracked");
   AST_ALERT: assert property (1'b1 |=> diagAlert == (|$past(linked)))
      else $error("display alert wrong");
   AST_ANALOG: assert property (1'b1 |=> analogAlert ==
      (|($past(linked) & ~ANALOG_EXCLUDE))) else $error("analog alert wrong");
   AST_FALLBACK_NAK: assert property (cfgWrite && cfgSel == SEL_FALLBACK
      && (cfgData < FALLBACK_MIN_UA || cfgData > FALLBACK_MAX_UA)
      |=> cfgNak && !cfgAck) else $error("fallback range not refused");
   AST_LIMIT_LOCK: assert property (cfgWrite && diagMode != DASA_STOP
      && (cfgSel == SEL_UPPER || cfgSel == SEL_LOWER) |=> cfgNak)
      else $error("limit written outside stop");
   AST_REF_START: assert property (cfgWrite && cfgSel == SEL_MODE
      && cfgData == {14'h0000, MODE_CODE_REF}
      |=> refSampleStart && diagMode == DASA_REF)
      else $error("reference start missing");
   AST_OVER_RANGE: assert property (diagnosticAlarmStatus[12]
      && $past(diagnosticAlarmStatus[12]) |-> !detectEnable)
      else $error("detection not suspended");
   cover property (cfgNak);
   cover property (analogAlert);
   cover property (diagMode == DASA_REF ##1 diagMode == DASA_CALC);
endmodule
bind dasa_alarm_bank dasa_alarm_bank_checker chk_u (.clk, .sys_rst,
   .cfgWrite, .cfgSel, .cfgData, .cfgAck, .cfgNak, .flangeTempLowFlag,
   .flangeTempHighFlag, .detectEnable, .refSampleStart, .diagAlert,
   .analogAlert, .diagnosticAlarmStatus, .alarmLinkMask, .diagMode);

// ### verif/dasa_alarm_bank_tb.sv
// self-checking bench for the alarm bank
`timescale 1ns/100ps
module dasa_alarm_bank_tb;
   import dasa_pkg::*;
   logic               clk, sys_rst, cfgWrite, cfgAck, cfgNak, resultValid;
   logic               refDone, flangeTempLowFlag, flangeTempHighFlag;
   logic               burnoutSwitchHigh, detectEnable, blockFactorEnable;
   logic               refSampleStart, diagAlert, analogAlert, a, n;
   logic [2:0]         cfgSel;
   logic [5:0]         blockResult, blk;
   logic [3:0]         refInvalid;
   logic signed [15:0] normalizedMeanPressure, referenceMeanPressure;
   logic [15:0]        cfgData, cfgReadData, pvCurrent, outputUpperBound;
   logic [15:0]        outputLowerBound, aoCurrent, diagnosticAlarmStatus;
   logic [15:0]        alarmLinkMask, mask, fb, st, ao;
   logic [31:0]        r, rngState = 32'h7D11;
   logic [1:0]         opt;
   dasa_mode_e         diagMode;
   int                 miscompares = 0, checks_done = 0, upper, lower;
   int                 fbv[4] = '{16'h0E0F, 16'h0E10, 16'h5461, 16'h5460};

   dasa_alarm_bank dut_u (.clk, .sys_rst, .cfgWrite, .cfgSel, .cfgData,
      .cfgAck, .cfgNak, .cfgReadData, .resultValid, .blockResult,
      .refInvalid, .refDone, .normalizedMeanPressure, .referenceMeanPressure,
      .flangeTempLowFlag, .flangeTempHighFlag, .pvCurrent, .outputUpperBound,
      .outputLowerBound, .burnoutSwitchHigh, .aoCurrent, .detectEnable,
      .blockFactorEnable, .refSampleStart, .diagAlert, .analogAlert,
      .diagnosticAlarmStatus, .alarmLinkMask, .diagMode);
   dasa_cfg_tool tool_u (.clk, .cfgAck, .cfgNak, .cfgWrite, .cfgSel,
      .cfgData);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      tally_and_finish();
   end

   function automatic logic [31:0] xs();
      rngState ^= rngState << 13;
      rngState ^= rngState >> 17;
      rngState ^= rngState << 5;
      return rngState;
   endfunction
   function automatic logic ovr(input logic signed [15:0] p);
      return p > upper || p < lower;
   endfunction
   task automatic chk(input string what, input logic [15:0] e, g);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   initial begin
      {sys_rst, resultValid, refDone, burnoutSwitchHigh} = 4'h8;
      {blockResult, refInvalid, flangeTempLowFlag, flangeTempHighFlag} = 0;
      {normalizedMeanPressure, referenceMeanPressure, pvCurrent} = 0;
      outputUpperBound = 16'h5460;
      outputLowerBound = 16'h0E10;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      chk("mask", MASK_RESET, alarmLinkMask);
      {upper, lower, blk, opt, fb} = {32'sd8192, -32'sd8192, 24'h000E10};
      tool_u.put(SEL_MODE, {14'h0000, MODE_CODE_CALC}, a, n);
      tool_u.put(SEL_UPPER, 16'h1000, a, n);
      chk("limit refused", 16'h0001, {15'h0000, n});
      tool_u.guarded(SEL_UPPER, 16'h1000, a);
      tool_u.guarded(SEL_LOWER, 16'hF000, a);
      {upper, lower} = {32'sd4096, -32'sd4096};
      for (int i = 0; i < 4; i++) begin
         tool_u.put(SEL_FALLBACK, 16'(fbv[i]), a, n);
         chk("fallback ack", 16'(i % 2), {15'h0000, a});
      end
      fb = 16'h5460;
      tool_u.put(SEL_MODE, 16'h0003, a, n);
      chk("mode code refused", 16'h0001, {15'h0000, n});
      tool_u.put(SEL_STATUS, 16'hFFFF, a, n);
      chk("status write refused", 16'h0001, {15'h0000, n});
      $display("config test done");
      for (int i = 0; i < 60; i++) begin
         r = xs();
         tool_u.guarded(SEL_MASK, r[15:0], a);
         mask = r[15:0] & 16'h7FFC;
         chk("mask", mask, alarmLinkMask);
         tool_u.put(SEL_OUT_OPTION, {14'h0000, r[17:16]}, a, n);
         if (r[17:16] != 2'h3) opt = r[17:16];
         chk("option nak", 16'(r[17:16] == 2'h3), 16'(n));
         @(negedge clk);
         r = xs();
         {burnoutSwitchHigh, blockResult, refInvalid} = r[10:0];
         {flangeTempLowFlag, flangeTempHighFlag} = r[12:11];
         normalizedMeanPressure = {{2{r[29]}}, r[29:16]};
         referenceMeanPressure = {{2{r[31]}}, r[31:18]};
         pvCurrent = 16'(xs());
         resultValid = 1'b1;
         if (!ovr(normalizedMeanPressure)) blk = blockResult;
         @(negedge clk);
         resultValid = 1'b0;
         repeat (3) @(negedge clk);
         st = {1'b0, flangeTempHighFlag, flangeTempLowFlag,
               ovr(normalizedMeanPressure),
               refInvalid | {4{ovr(referenceMeanPressure)}}, blk, 2'b00};
         ao = (opt == OUT_BURNOUT) ? (burnoutSwitchHigh ? 16'h5460 : 16'h0E10)
            : (opt == OUT_FALLBACK) ? fb : pvCurrent;
         if (!(|(st & mask & ~ANALOG_EXCLUDE))) ao = pvCurrent;
         chk("status", st, diagnosticAlarmStatus);
         chk("readback", st, cfgReadData);
         chk("display alert", 16'(|(st & mask)), 16'(diagAlert));
         chk("analog output", ao, aoCurrent);
         chk("detect", 16'(!st[12]), 16'(detectEnable));
         chk("factor", 16'(!st[12] && !st[8]), 16'(blockFactorEnable));
      end
      $display("status test done");
      tool_u.put(SEL_MODE, {14'h0000, MODE_CODE_REF}, a, n);
      chk("sample start", 16'h0001, {15'h0000, refSampleStart});
      chk("blockage cleared", 16'h0000,
          {10'h000, diagnosticAlarmStatus[7:2]});
      @(negedge clk);
      refDone = 1'b1;
      @(negedge clk);
      refDone = 1'b0;
      chk("mode", {14'h0000, DASA_CALC}, {14'h0000, diagMode});
      $display("reference test done");
      tally_and_finish();
   end
endmodule
